/* design/alarm_type_evaluator.sv */
`timescale 1ns/1ns
module alarm_type_evaluator
(
  // clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_nrst,
  // apb slave
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [11:0]              i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic [31:0]                   o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  // control loop
  input  wire logic                     i_sample_tick,
  input  wire alarm_pkg::loop_values_t  i_loop,
  // auxiliary alarm outputs
  output logic [2:0]                    o_alarm
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    SEL_NONE = 4'b0001,
    SEL_CTRL = 4'b0010,
    SEL_GLOB = 4'b0100,
    SEL_CHAN = 4'b1000
  } reg_sel_t;

  typedef struct packed {
    reg_sel_t    sel;
    logic [11:0] word;
    logic [1:0]  ch;
  } reg_hit_t;

  // shared by read and write paths; unaligned or out-of-map -> SEL_NONE
  function automatic reg_hit_t decode(input logic [11:0] a);
    reg_hit_t    h;
    logic [11:0] rel;
    h.sel  = SEL_NONE;
    h.word = a;
    h.ch   = 2'b00;
    rel    = a - alarm_pkg::OFS_CH_BASE;
    if (a == alarm_pkg::OFS_CTRL)
      h.sel = SEL_CTRL;
    else if (a == alarm_pkg::OFS_HYST || a == alarm_pkg::OFS_STATUS)
      h.sel = SEL_GLOB;
    else if (a >= alarm_pkg::OFS_CH_BASE &&
             rel < 12'(alarm_pkg::NCH) * alarm_pkg::CH_STRIDE &&
             rel[1:0] == 2'b00 &&
             rel[3:2] != 2'b11)
    begin
      h.sel  = SEL_CHAN;
      h.ch   = rel[5:4];
      h.word = {8'h00, rel[3:0]};
    end
    return h;
  endfunction

  // type codes that software may place in a given channel
  function automatic logic type_legal(input logic [4:0] t,
                                      input logic [1:0] ch,
                                      input logic       remote_use);
    logic ok;
    ok = (t <= alarm_pkg::TYPE_RMT_LO);
    if (t == alarm_pkg::TYPE_LOOP_BRK && ch != 2'b00)
      ok = 1'b0;
    if ((t == alarm_pkg::TYPE_RMT_UP || t == alarm_pkg::TYPE_RMT_LO) &&
        !remote_use)
      ok = 1'b0;
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam alarm_pkg::alarm_state_t RESET_STATE = '{
    heat_cool:  1'b0,
    remote_use: 1'b0,
    hyst:       alarm_pkg::RST_HYST,
    type_sel:   {alarm_pkg::NCH{alarm_pkg::RST_TYPE}},
    val_h:      {alarm_pkg::NCH{alarm_pkg::RST_VAL}},
    val_l:      {alarm_pkg::NCH{alarm_pkg::RST_VAL}},
    alarm:      3'h0,
    standby:    3'h7,
    prdata:     32'h0000_0000
  };

  alarm_pkg::alarm_state_t state_reg;
  alarm_pkg::alarm_state_t state_next;

  logic signed [17:0] margin   [alarm_pkg::NCH];
  logic [2:0]         active;
  logic [2:0]         sby_type;
  logic [2:0]         overlap;

  reg_hit_t           hit;
  logic               setup_ph;
  logic               wr_access;
  logic               bad_type;

  // ----------------------------------------------------------------
  // per-channel comparison
  // ----------------------------------------------------------------
  for (genvar c = 0; c < alarm_pkg::NCH; c++)
  begin : g_ch
    alarm_channel_eval
    #(
      .FIRST_CH (c == 0)
    )
    u_eval
    (
      .i_type_sel     (state_reg.type_sel[c]),
      .i_val_h        (state_reg.val_h[c]),
      .i_val_l        (state_reg.val_l[c]),
      .i_hyst         (state_reg.hyst),
      .i_heat_cool    (state_reg.heat_cool),
      .i_remote_use   (state_reg.remote_use),
      .i_loop         (i_loop),
      .o_margin       (margin[c]),
      .o_active       (active[c]),
      .o_standby_type (sby_type[c]),
      .o_overlap      (overlap[c])
    );
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait-free access phase: read data is latched in the setup phase
  assign hit       = decode(i_paddr);
  assign setup_ph  = i_psel && !i_penable;
  assign wr_access = i_psel && i_penable && i_pwrite;
  assign bad_type  = hit.sel == SEL_CHAN && hit.word == alarm_pkg::CH_TYPE &&
                     !type_legal(i_pwdata[4:0], hit.ch, state_reg.remote_use);
  assign o_pready  = i_psel && i_penable;
  assign o_pslverr = o_pready && (hit.sel == SEL_NONE || (i_pwrite && bad_type));
  assign o_prdata  = state_reg.prdata;
  assign o_alarm   = state_reg.alarm;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;

    // alarm evaluation, once per sampling tick
    if (i_sample_tick)
    begin
      for (int c = 0; c < alarm_pkg::NCH; c++)
      begin
        if (!active[c])
          state_next.alarm[c] = 1'b0;
        else if (overlap[c])
          state_next.alarm[c] = 1'b0;
        else if (sby_type[c] && state_reg.standby[c])
        begin
          // held off until the value is first seen clear of the condition
          state_next.alarm[c] = 1'b0;
          if (margin[c] < 0)
            state_next.standby[c] = 1'b0;
        end
        else if (margin[c] >= 0)
          state_next.alarm[c] = 1'b1;
        else if (margin[c] + $signed({2'b00, state_reg.hyst}) < 0)
          state_next.alarm[c] = 1'b0;         // hysteresis keeps chatter off
      end
    end

    // read data is captured in the setup phase and held through access
    if (setup_ph)
    begin
      state_next.prdata = 32'h0000_0000;
      case (hit.sel)
        SEL_CTRL:
        begin
          state_next.prdata[alarm_pkg::CTRL_HEAT_COOL]  = state_reg.heat_cool;
          state_next.prdata[alarm_pkg::CTRL_REMOTE_USE] = state_reg.remote_use;
        end
        SEL_GLOB:
        begin
          if (hit.word == alarm_pkg::OFS_HYST)
            state_next.prdata[15:0] = state_reg.hyst;
          else
          begin
            state_next.prdata[2:0] = state_reg.alarm;
            state_next.prdata[alarm_pkg::STAT_STANDBY +: 3] = state_reg.standby;
          end
        end
        SEL_CHAN:
        begin
          if (hit.word == alarm_pkg::CH_TYPE)
            state_next.prdata[4:0] = state_reg.type_sel[hit.ch];
          else if (hit.word == alarm_pkg::CH_VAL_H)
            state_next.prdata[15:0] = state_reg.val_h[hit.ch];
          else
            state_next.prdata[15:0] = state_reg.val_l[hit.ch];
        end
        default:
          state_next.prdata = 32'h0000_0000;
      endcase
    end

    // writes take effect in the access phase; a refused type keeps the old
    if (wr_access)
    begin
      case (hit.sel)
        SEL_CTRL:
        begin
          state_next.heat_cool  = i_pwdata[alarm_pkg::CTRL_HEAT_COOL];
          state_next.remote_use = i_pwdata[alarm_pkg::CTRL_REMOTE_USE];
        end
        SEL_GLOB:
        begin
          if (hit.word == alarm_pkg::OFS_HYST)
            state_next.hyst = i_pwdata[15:0];
        end
        SEL_CHAN:
        begin
          if (hit.word == alarm_pkg::CH_TYPE)
          begin
            if (!bad_type)
            begin
              // a new type restarts from a clean, standing-by channel
              state_next.type_sel[hit.ch] = i_pwdata[4:0];
              state_next.alarm[hit.ch]    = 1'b0;
              state_next.standby[hit.ch]  = 1'b1;
            end
          end
          else if (hit.word == alarm_pkg::CH_VAL_H)
            state_next.val_h[hit.ch] = i_pwdata[15:0];
          else
            state_next.val_l[hit.ch] = i_pwdata[15:0];
        end
        default:
          state_next.heat_cool = state_reg.heat_cool;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      state_reg <= RESET_STATE;
    else
      state_reg <= state_next;
  end

endmodule

/* design/alarm_pkg.sv */
// Notes on behaviour
// - code 8: alarm while process above threshold
// - code 9: alarm while process below threshold
// - code 6 is code 2 plus standby
// - code 7 is code 3 plus standby
// - code 10 is code 8 plus standby
// - code 11 is code 9 plus standby
// - loop-break code 12 only on channel 0
// - code 14: alarm while local target above threshold
// - code 15: alarm while local target below threshold
// - code 16: alarm while output above threshold
// - code 17: alarm while output below threshold
// - heat/cool: upper uses heating, lower cooling
// - code 18: alarm while remote target above threshold
// - code 19: alarm while remote target below threshold
// - remote codes only with remote input in use
// - codes 1,4,5 keep separate upper, lower deviations
// - code 5 off while hysteresis bands overlap
// - code 2: process above target by deviation
// - code 3: process below target by deviation
// - code 1: process outside deviation band
package alarm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 3;
  localparam int W   = 16;
  localparam int MW  = 18;
  localparam int AW  = 12;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL    = 12'h000;
  localparam logic [AW-1:0] OFS_HYST    = 12'h004;
  localparam logic [AW-1:0] OFS_STATUS  = 12'h008;
  localparam logic [AW-1:0] OFS_CH_BASE = 12'h010;
  localparam logic [AW-1:0] CH_STRIDE   = 12'h010;
  localparam logic [AW-1:0] CH_TYPE     = 12'h000;
  localparam logic [AW-1:0] CH_VAL_H    = 12'h004;
  localparam logic [AW-1:0] CH_VAL_L    = 12'h008;

  // field positions
  localparam int CTRL_HEAT_COOL  = 0;
  localparam int CTRL_REMOTE_USE = 1;
  localparam int STAT_STANDBY    = 4;

  // ----------------------------------------------------------------
  // alarm type codes
  // ----------------------------------------------------------------
  localparam logic [4:0] TYPE_OFF       = 5'h00;
  localparam logic [4:0] TYPE_BAND_OUT  = 5'h01;
  localparam logic [4:0] TYPE_DEV_UP    = 5'h02;
  localparam logic [4:0] TYPE_DEV_LO    = 5'h03;
  localparam logic [4:0] TYPE_BAND_IN   = 5'h04;
  localparam logic [4:0] TYPE_BAND_SBY  = 5'h05;
  localparam logic [4:0] TYPE_DEV_UP_S  = 5'h06;
  localparam logic [4:0] TYPE_DEV_LO_S  = 5'h07;
  localparam logic [4:0] TYPE_ABS_UP    = 5'h08;
  localparam logic [4:0] TYPE_ABS_LO    = 5'h09;
  localparam logic [4:0] TYPE_ABS_UP_S  = 5'h0a;
  localparam logic [4:0] TYPE_ABS_LO_S  = 5'h0b;
  localparam logic [4:0] TYPE_LOOP_BRK  = 5'h0c;
  localparam logic [4:0] TYPE_RATE      = 5'h0d;
  localparam logic [4:0] TYPE_TGT_UP    = 5'h0e;
  localparam logic [4:0] TYPE_TGT_LO    = 5'h0f;
  localparam logic [4:0] TYPE_OUT_UP    = 5'h10;
  localparam logic [4:0] TYPE_OUT_LO    = 5'h11;
  localparam logic [4:0] TYPE_RMT_UP    = 5'h12;
  localparam logic [4:0] TYPE_RMT_LO    = 5'h13;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]   RST_TYPE = TYPE_DEV_UP;
  localparam logic [W-1:0] RST_VAL  = 16'h0000;
  localparam logic [W-1:0] RST_HYST = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [W-1:0] process_value;
    logic signed [W-1:0] local_target;
    logic signed [W-1:0] remote_target;
    logic signed [W-1:0] manipulated_output;
    logic signed [W-1:0] cool_output;
  } loop_values_t;

  typedef struct packed {
    logic                         heat_cool;
    logic                         remote_use;
    logic [W-1:0]                 hyst;
    logic [NCH-1:0][4:0]          type_sel;
    logic [NCH-1:0][W-1:0]        val_h;
    logic [NCH-1:0][W-1:0]        val_l;
    logic [NCH-1:0]               alarm;
    logic [NCH-1:0]               standby;
    logic [31:0]                  prdata;
  } alarm_state_t;

endpackage

/* design/alarm_channel_eval.sv */
`timescale 1ns/1ns
module alarm_channel_eval
#(
  parameter bit FIRST_CH = 1'b0
)
(
  // configuration
  input  wire logic [4:0]               i_type_sel,
  input  wire logic [15:0]              i_val_h,
  input  wire logic [15:0]              i_val_l,
  input  wire logic [15:0]              i_hyst,
  input  wire logic                     i_heat_cool,
  input  wire logic                     i_remote_use,
  // sampled loop values
  input  wire alarm_pkg::loop_values_t  i_loop,
  // evaluation
  output logic signed [17:0]            o_margin,
  output logic                          o_active,
  output logic                          o_standby_type,
  output logic                          o_overlap
);

  // sign extension to the margin width; 16-bit sums of three terms fit in 18
  function automatic logic signed [17:0] ext(input logic [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  logic signed [17:0] pv;
  logic signed [17:0] sp;
  logic signed [17:0] rsp;
  logic signed [17:0] up_out;
  logic signed [17:0] lo_out;
  logic signed [17:0] x;
  logic signed [17:0] l;
  logic signed [17:0] above;
  logic signed [17:0] below;

  // margin >= 0 means the alarm condition holds; strict compares subtract one
  always_comb
  begin
    pv     = ext(i_loop.process_value);
    sp     = ext(i_loop.local_target);
    rsp    = ext(i_loop.remote_target);
    up_out = ext(i_loop.manipulated_output);
    lo_out = i_heat_cool ? ext(i_loop.cool_output)
                         : ext(i_loop.manipulated_output);
    x      = ext(i_val_h);
    l      = ext(i_val_l);
    above  = pv - sp - x;
    below  = sp - l - pv;
    o_margin       = 18'sh0_0000;
    o_active       = 1'b1;
    o_standby_type = 1'b0;
    case (i_type_sel)
      alarm_pkg::TYPE_BAND_OUT, alarm_pkg::TYPE_BAND_SBY:
        o_margin = (above > below) ? above : below;
      alarm_pkg::TYPE_BAND_IN:
        o_margin = (above > below) ? -above : -below;
      alarm_pkg::TYPE_DEV_UP, alarm_pkg::TYPE_DEV_UP_S:
        o_margin = pv - sp - x;
      alarm_pkg::TYPE_DEV_LO, alarm_pkg::TYPE_DEV_LO_S:
        o_margin = sp - pv - x;
      alarm_pkg::TYPE_ABS_UP, alarm_pkg::TYPE_ABS_UP_S:
        o_margin = pv - x - 18'sh0_0001;
      alarm_pkg::TYPE_ABS_LO, alarm_pkg::TYPE_ABS_LO_S:
        o_margin = x - pv - 18'sh0_0001;
      alarm_pkg::TYPE_TGT_UP:
        o_margin = sp - x - 18'sh0_0001;
      alarm_pkg::TYPE_TGT_LO:
        o_margin = x - sp - 18'sh0_0001;
      alarm_pkg::TYPE_OUT_UP:
        o_margin = up_out - x - 18'sh0_0001;
      alarm_pkg::TYPE_OUT_LO:
        o_margin = x - lo_out - 18'sh0_0001;
      alarm_pkg::TYPE_RMT_UP:
      begin
        o_margin = rsp - x - 18'sh0_0001;
        o_active = i_remote_use;
      end
      alarm_pkg::TYPE_RMT_LO:
      begin
        o_margin = x - rsp - 18'sh0_0001;
        o_active = i_remote_use;
      end
      alarm_pkg::TYPE_LOOP_BRK:
        o_active = 1'b0;                          // only legal on FIRST_CH
      default:
        o_active = 1'b0;
    endcase
    case (i_type_sel)
      alarm_pkg::TYPE_BAND_SBY, alarm_pkg::TYPE_DEV_UP_S,
      alarm_pkg::TYPE_DEV_LO_S, alarm_pkg::TYPE_ABS_UP_S,
      alarm_pkg::TYPE_ABS_LO_S:
        o_standby_type = 1'b1;
      default:
        o_standby_type = 1'b0;
    endcase
    if (!FIRST_CH && i_type_sel == alarm_pkg::TYPE_LOOP_BRK)
      o_active = 1'b0;
    // upper off point meets lower off point: H + L <= 2 * hysteresis
    o_overlap = (i_type_sel == alarm_pkg::TYPE_BAND_SBY) &&
                ((x + l) <= $signed({1'b0, i_hyst, 1'b0}));
  end

endmodule

/* tb/alarm_loop_model.sv */
`timescale 1ns/1ns
module alarm_loop_model
(
  // clock
  input  wire logic             i_ref_clk,
  // sampled loop values
  output logic                  o_sample_tick,
  output alarm_pkg::loop_values_t o_loop
);
  // ----------------------------------------------------------------
  // control loop stand-in
  // ----------------------------------------------------------------
  initial
  begin
    o_sample_tick = 1'b0;
    o_loop = '0;
  end

  // one tick per sample; between ticks the values are inverted so that
  // an evaluator that samples off the tick sees garbage, not a copy
  task automatic sample(input alarm_pkg::loop_values_t v);
    @(posedge i_ref_clk);
    o_sample_tick <= 1'b1;
    o_loop <= v;
    @(posedge i_ref_clk);
    o_sample_tick <= 1'b0;
    o_loop <= ~v;
  endtask
endmodule

/* tb/alarm_type_evaluator_chk.sv */
`timescale 1ns/1ns
module alarm_type_evaluator_chk
(
  // clock and reset
  input wire logic                    i_ref_clk,
  input wire logic                    i_nrst,
  // apb slave
  input wire logic                    i_psel,
  input wire logic                    i_penable,
  input wire logic                    i_pwrite,
  input wire logic [11:0]             i_paddr,
  input wire logic [31:0]             i_pwdata,
  input wire logic [31:0]             o_prdata,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  // loop and alarms
  input wire logic                    i_sample_tick,
  input wire alarm_pkg::loop_values_t i_loop,
  input wire logic [2:0]              o_alarm
);
  // ----------------------------------------------------------------
  // helpers: channel 0 settings as left by accepted writes
  // ----------------------------------------------------------------
  logic              acc;
  logic              typ_wr;
  logic [4:0]        ty0_reg;
  logic signed [15:0] h0_reg;
  assign acc = i_psel && i_penable;
  assign typ_wr = acc && i_pwrite && (i_paddr == 12'h010 || i_paddr == 12'h020
                  || i_paddr == 12'h030);

  // refused writes leave the mirror alone, as they leave the device alone
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      ty0_reg <= 5'h02;
      h0_reg <= 16'h0000;
    end
    else if (acc && i_pwrite && !o_pslverr)
    begin
      if (i_paddr == 12'h010)
        ty0_reg <= i_pwdata[4:0];
      if (i_paddr == 12'h014)
        h0_reg <= i_pwdata[15:0];
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  sequence ch0_set_s;
    acc && i_pwrite && i_paddr == 12'h010 && !o_pslverr && !i_sample_tick;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_pready_acc: assert property (acc |-> o_pready)
    else $error("pready low in access phase");
  chk_pready_idle: assert property (!acc |-> !o_pready)
    else $error("pready high outside access");
  chk_err_misalign: assert property (acc && i_paddr[1:0] != 2'b00 |-> o_pslverr)
    else $error("misaligned access not refused");
  chk_err_idle: assert property (!acc |-> !o_pslverr)
    else $error("pslverr outside access");
  chk_loop_brk_ch: assert property (
    typ_wr && i_paddr != 12'h010 && i_pwdata[4:0] == 5'h0c |-> o_pslverr)
    else $error("loop break code taken on later channel");
  chk_type_range: assert property (typ_wr && i_pwdata[4:0] > 5'h13 |-> o_pslverr)
    else $error("type code above range taken");
  chk_alarm_hold: assert property (
    !i_sample_tick && !(acc && i_pwrite) |=> $stable(o_alarm))
    else $error("alarm moved without a tick");
  chk_off_quiet: assert property (i_sample_tick && ty0_reg == 5'h00 |=> !o_alarm[0])
    else $error("alarm raised with function off");
  chk_abs_upper: assert property (
    i_sample_tick && ty0_reg == 5'h08 && i_loop.process_value > h0_reg |=> o_alarm[0])
    else $error("absolute upper alarm missing");
  chk_abs_lower: assert property (
    i_sample_tick && ty0_reg == 5'h09 && i_loop.process_value < h0_reg |=> o_alarm[0])
    else $error("absolute lower alarm missing");
  chk_type_clear: assert property (ch0_set_s |=> !o_alarm[0])
    else $error("alarm kept over a type change");
endmodule

bind alarm_type_evaluator alarm_type_evaluator_chk chk (.i_ref_clk(i_ref_clk),
  .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_sample_tick(i_sample_tick), .i_loop(i_loop),
  .o_alarm(o_alarm));

/* tb/alarm_type_evaluator_test.sv */
`timescale 1ns/1ns
module alarm_type_evaluator_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick;
  logic [2:0]  alarm;
  alarm_pkg::loop_values_t loop;
  alarm_pkg::loop_values_t lv;
  int          mismatches = 0;
  int          n_checks = 0;
  int          ch = 0;
  int          cc = 0;

  always #20 clk = ~clk;

  alarm_loop_model loop_m (.i_ref_clk(clk), .o_sample_tick(tick), .o_loop(loop));

  alarm_type_evaluator DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sample_tick(tick), .i_loop(loop), .o_alarm(alarm));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one transfer; a slave that never answers is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic ee, output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    check("pslverr", {31'h0, pslverr}, {31'h0, ee});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    apb(1'b1, a, d, 1'b0, v);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    apb(1'b0, a, 32'h0000_0000, 1'b0, v);
    check("read", v, e);
  endtask

  function automatic logic [11:0] ca(input int c, input logic [11:0] off);
    return alarm_pkg::OFS_CH_BASE + alarm_pkg::CH_STRIDE * 12'(c) + off;
  endfunction

  // one sample of lv, then the alarm of the current channel
  task automatic ts(input logic ex);
    loop_m.sample(lv);
    #1;
    check("alarm", {31'h0, alarm[ch]}, {31'h0, ex});
  endtask

  // f picks the field that carries x: pv, sp, rsp, mo, co; the rest sit at 50
  task automatic run_case(input logic [4:0] ty, input logic hc, input int f,
                          input logic [15:0] h, l, x, input logic ex);
    ch = cc % 3;
    cc++;
    lv = {5{16'h0032}};
    lv[79-16*f -: 16] = x;
    wr(alarm_pkg::OFS_CTRL, {30'h0, 1'b1, hc});
    wr(ca(ch, alarm_pkg::CH_TYPE), {27'h0, ty});
    wr(ca(ch, alarm_pkg::CH_VAL_H), {16'h0000, h});
    wr(ca(ch, alarm_pkg::CH_VAL_L), {16'h0000, l});
    ts(ex);
  endtask

  // standby: alarming first sample is held off, quiet sample arms, then normal
  task automatic sby(input logic [4:0] ty, input logic [15:0] h, l, pa, pq,
                     input logic ex);
    logic [31:0] v;
    ch = 0;
    lv = {5{16'h0032}};
    wr(alarm_pkg::OFS_CTRL, 32'h0000_0002);
    wr(ca(0, alarm_pkg::CH_TYPE), {27'h0, ty});
    wr(ca(0, alarm_pkg::CH_VAL_H), {16'h0000, h});
    wr(ca(0, alarm_pkg::CH_VAL_L), {16'h0000, l});
    lv.process_value = pa;
    ts(1'b0);
    apb(1'b0, alarm_pkg::OFS_STATUS, 32'h0000_0000, 1'b0, v);
    check("standby", {31'h0, v[4]}, 32'h0000_0001);
    lv.process_value = pq;
    ts(1'b0);
    lv.process_value = pa;
    ts(ex);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] v;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdc(alarm_pkg::OFS_CTRL, 32'h0000_0000);
    rdc(alarm_pkg::OFS_HYST, 32'h0000_0000);
    for (int c = 0; c < 3; c++)
    begin
      rdc(ca(c, alarm_pkg::CH_TYPE), 32'h0000_0002);
      rdc(ca(c, alarm_pkg::CH_VAL_H), 32'h0000_0000);
    end
    rdc(alarm_pkg::OFS_STATUS, 32'h0000_0070);
    // holes in the map answer with an error, read zero and store nothing; a type code above range is refused too
    apb(1'b0, 12'h00c, 32'h0000_0000, 1'b1, v);
    check("unmapped", v, 32'h0000_0000);
    apb(1'b1, 12'h002, 32'h0000_0003, 1'b1, v);
    rdc(alarm_pkg::OFS_CTRL, 32'h0000_0000);
    apb(1'b1, ca(1, alarm_pkg::CH_TYPE), 32'h0000_0014, 1'b1, v);
    rdc(ca(1, alarm_pkg::CH_TYPE), 32'h0000_0002);
    // loop break: first channel only, and it never alarms here
    apb(1'b1, ca(0, alarm_pkg::CH_TYPE), 32'h0000_000c, 1'b0, v);
    lv = {5{16'h7fff}};
    ts(1'b0);
    apb(1'b1, ca(2, alarm_pkg::CH_TYPE), 32'h0000_000c, 1'b1, v);
    rdc(ca(2, alarm_pkg::CH_TYPE), 32'h0000_0002);
    apb(1'b1, ca(0, alarm_pkg::CH_TYPE), 32'h0000_0012, 1'b1, v);
    rdc(ca(0, alarm_pkg::CH_TYPE), 32'h0000_000c);
    run_case(5'h08, 1'b0, 0, 16'h0064, 16'h0000, 16'h0065, 1'b1);
    run_case(5'h08, 1'b0, 0, 16'h0064, 16'h0000, 16'h0064, 1'b0);
    run_case(5'h09, 1'b0, 0, 16'h0064, 16'h0000, 16'h0063, 1'b1);
    run_case(5'h09, 1'b0, 0, 16'h0000, 16'h0000, 16'hfffb, 1'b1);
    run_case(5'h02, 1'b0, 0, 16'h000a, 16'h0000, 16'h003c, 1'b1);
    run_case(5'h02, 1'b0, 0, 16'h000a, 16'h0000, 16'h003b, 1'b0);
    run_case(5'h00, 1'b0, 0, 16'h0000, 16'h0000, 16'h7fff, 1'b0);
    run_case(5'h03, 1'b0, 0, 16'h000a, 16'h0000, 16'h0028, 1'b1);
    run_case(5'h03, 1'b0, 0, 16'h000a, 16'h0000, 16'h0029, 1'b0);
    run_case(5'h01, 1'b0, 0, 16'h000a, 16'h0005, 16'h002d, 1'b1);
    run_case(5'h01, 1'b0, 0, 16'h000a, 16'h0005, 16'h002e, 1'b0);
    run_case(5'h01, 1'b0, 0, 16'h000a, 16'h0005, 16'h003c, 1'b1);
    run_case(5'h04, 1'b0, 0, 16'h000a, 16'h0005, 16'h0037, 1'b1);
    run_case(5'h04, 1'b0, 0, 16'h000a, 16'h0005, 16'h002c, 1'b0);
    run_case(5'h0e, 1'b0, 1, 16'h0014, 16'h0000, 16'h0015, 1'b1);
    run_case(5'h0f, 1'b0, 1, 16'h0014, 16'h0000, 16'h0013, 1'b1);
    run_case(5'h10, 1'b0, 3, 16'h0014, 16'h0000, 16'h001e, 1'b1);
    run_case(5'h11, 1'b0, 3, 16'h0014, 16'h0000, 16'h000a, 1'b1);
    run_case(5'h11, 1'b1, 3, 16'h0014, 16'h0000, 16'h000a, 1'b0);
    run_case(5'h11, 1'b1, 4, 16'h0014, 16'h0000, 16'h000a, 1'b1);
    run_case(5'h10, 1'b1, 3, 16'h0014, 16'h0000, 16'h001e, 1'b1);
    run_case(5'h13, 1'b0, 2, 16'h0014, 16'h0000, 16'h000a, 1'b1);
    run_case(5'h12, 1'b0, 2, 16'h0014, 16'h0000, 16'h001e, 1'b1);
    wr(alarm_pkg::OFS_CTRL, 32'h0000_0000);
    ts(1'b0);
    sby(5'h05, 16'h000a, 16'h000a, 16'h0046, 16'h0032, 1'b1);
    sby(5'h06, 16'h000a, 16'h0000, 16'h003c, 16'h0032, 1'b1);
    sby(5'h07, 16'h000a, 16'h0000, 16'h0028, 16'h0032, 1'b1);
    sby(5'h0a, 16'h0064, 16'h0000, 16'h0096, 16'h0032, 1'b1);
    sby(5'h0b, 16'h0064, 16'h0000, 16'h0032, 16'h0096, 1'b1);
    wr(alarm_pkg::OFS_HYST, 32'h0000_000a);
    sby(5'h05, 16'h000a, 16'h000a, 16'h0046, 16'h0032, 1'b0);
    complete_run();
  end

  // watchdog, far beyond the roughly 520 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule
